// File: rtl/acr_pkg.sv
// How it works
// - mic gain code 00/01 gives 0 dB, 10 gives 6 dB, 11 gives 12 dB
// - clock ratio code 00/11 is 256 Fs, 01 is 384 Fs, 10 is 512 Fs
// - rate codes 0..8 select 48 down to 8 kHz; reset is 48 kHz
// - format 00: playback 16-bit right justified, record 16-bit left justified
// - format 01: playback 20-bit right justified, record 20-bit left justified
// - format 10: both directions 20-bit left justified
// - format 11, reset value: both directions 20-bit I2S
// - record word: left mute 15, left gain 14:8, right mute 7, right gain 6:0
// - gain code steps 0.5 dB; 7F is +20, 57 is 0, 07 is -40 dB
// - gain code below 07 mutes the channel like its mute bit
// - left mute ramps gain down to lowest level, then mutes
// - unmute ramps back up to the kept gain code
// - right mute ramps down independently before muting
// - every record gain change is stepped, never jumped
// - reset: both mutes set, both gains 1010111
// - muted channel input is tied to the common-mode reference
// - control fields live in the audio control word at address 00h
package acr_pkg;

    localparam logic [3:0]  ACR_ADDR_CTRL   = 4'h0;
    localparam logic [3:0]  ACR_ADDR_GAIN   = 4'h1;
    localparam logic [15:0] ACR_CTRL_RESET  = 16'h0003;
    localparam logic [15:0] ACR_GAIN_RESET  = 16'hD7D7;
    localparam logic [6:0]  ACR_GAIN_MIN    = 7'h07;
    localparam logic [6:0]  ACR_GAIN_UNITY  = 7'h57;
    localparam logic [6:0]  ACR_GAIN_MAX    = 7'h7F;
    localparam logic [3:0]  ACR_RATE_LAST   = 4'h8;
    localparam int          ACR_MIC_POS     = 8;
    localparam int          ACR_RATIO_POS   = 6;
    localparam int          ACR_RATE_POS    = 2;
    localparam int          ACR_FMT_POS     = 0;
    localparam int          ACR_LMUTE_POS   = 15;
    localparam int          ACR_LGAIN_POS   = 8;
    localparam int          ACR_RMUTE_POS   = 7;
    localparam int          ACR_RGAIN_POS   = 0;

    typedef enum logic [1:0]
    {
        ACR_FMT_RJ16 = 2'b00,
        ACR_FMT_RJ20 = 2'b01,
        ACR_FMT_LJ20 = 2'b10,
        ACR_FMT_I2S  = 2'b11
    } acr_fmt_t;

    // framing decoded for the serial audio link
    typedef struct packed
    {
        logic [4:0] play_bits;
        logic       play_right_just;
        logic       play_i2s;
        logic [4:0] rec_bits;
        logic       rec_i2s;
    } acr_frame_t;

    typedef struct packed
    {
        logic [3:0]  mic_gain_db;
        logic [9:0]  mclk_ratio;
        logic [16:0] rate_hz_x10;
        logic [3:0]  rate_code;
        acr_frame_t  frame;
    } acr_cfg_t;

endpackage

// File: rtl/acr_regs.sv
`timescale 1ns/100ps
module acr_regs
    import acr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic [3:0]  rd_addr,
    output logic      [15:0] rd_data,
    input  wire logic        frame_sync,
    output acr_cfg_t         cfg,
    output logic      [6:0]  rec_left_applied,
    output logic      [6:0]  rec_right_applied,
    output logic             rec_left_to_common_mode_ref,
    output logic             rec_right_to_common_mode_ref
);

    // ****************************************************************
    // decoding helpers
    // ****************************************************************
    function automatic logic [3:0] mic_db(input logic [1:0] c);
        case (c)
            2'b10:   mic_db = 4'h6;
            2'b11:   mic_db = 4'hC;
            default: mic_db = 4'h0;
        endcase
    endfunction

    function automatic logic [9:0] ratio(input logic [1:0] c);
        case (c)
            2'b01:   ratio = 10'h180;
            2'b10:   ratio = 10'h200;
            default: ratio = 10'h100;
        endcase
    endfunction

    // rate in units of 0.01 kHz scaled as Hz/10
    function automatic logic [16:0] rate(input logic [3:0] c);
        case (c)
            4'h1:    rate = 17'h113A;
            4'h2:    rate = 17'h0C80;
            4'h3:    rate = 17'h0960;
            4'h4:    rate = 17'h089D;
            4'h5:    rate = 17'h0640;
            4'h6:    rate = 17'h04B0;
            4'h7:    rate = 17'h0451;
            4'h8:    rate = 17'h0320;
            default: rate = 17'h12C0;
        endcase
    endfunction

    function automatic acr_frame_t framing(input logic [1:0] c);
        acr_frame_t f;
        f = '{play_bits: 5'h14, play_right_just: 1'b0, play_i2s: 1'b0, rec_bits: 5'h14, rec_i2s: 1'b0};
        case (acr_fmt_t'(c))
            ACR_FMT_RJ16:
            begin
                f.play_bits       = 5'h10;
                f.play_right_just = 1'b1;
                f.rec_bits        = 5'h10;
            end
            ACR_FMT_RJ20: f.play_right_just = 1'b1;
            ACR_FMT_LJ20: f.play_right_just = 1'b0;
            ACR_FMT_I2S:
            begin
                f.play_i2s = 1'b1;
                f.rec_i2s  = 1'b1;
            end
            default: f.play_i2s = 1'b0;
        endcase
        framing = f;
    endfunction

    // ****************************************************************
    // register storage
    // ****************************************************************
    logic [15:0] ctrl_q;
    logic [15:0] gain_q;
    logic [15:0] ctrl_live_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ctrl_q <= ACR_CTRL_RESET;
        else if (wr_en && wr_addr == ACR_ADDR_CTRL)
            ctrl_q <= {6'h00, wr_data[9:0]};
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            gain_q <= ACR_GAIN_RESET;
        else if (wr_en && wr_addr == ACR_ADDR_GAIN)
            gain_q <= wr_data;
    end

    // clocking and framing only switch between frames to avoid torn words
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ctrl_live_q <= ACR_CTRL_RESET;
        else if (frame_sync)
            ctrl_live_q <= ctrl_q;
    end

    always_comb
    begin
        case (rd_addr)
            ACR_ADDR_CTRL: rd_data = ctrl_q;
            ACR_ADDR_GAIN: rd_data = gain_q;
            default:       rd_data = 16'h0000;
        endcase
    end

    always_comb
    begin
        cfg.mic_gain_db = mic_db(ctrl_live_q[ACR_MIC_POS +: 2]);
        cfg.mclk_ratio  = ratio(ctrl_live_q[ACR_RATIO_POS +: 2]);
        cfg.rate_code   = ctrl_live_q[ACR_RATE_POS +: 4];
        cfg.rate_hz_x10 = rate(ctrl_live_q[ACR_RATE_POS +: 4]);
        cfg.frame       = framing(ctrl_live_q[ACR_FMT_POS +: 2]);
    end

    // ****************************************************************
    // soft-stepped record gain, one channel per generate pass
    // ****************************************************************
    logic [1:0] mute_bits;
    logic [6:0] gain_codes [2];
    logic [6:0] applied    [2];
    logic [1:0] hard_mute;

    assign mute_bits     = {gain_q[ACR_RMUTE_POS], gain_q[ACR_LMUTE_POS]};
    assign gain_codes[0] = gain_q[ACR_LGAIN_POS +: 7];
    assign gain_codes[1] = gain_q[ACR_RGAIN_POS +: 7];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_ch
            logic [6:0] app_q;
            logic       mute_q;
            logic       want_mute;
            logic [6:0] target;

            // low codes behave like the mute bit
            assign want_mute = mute_bits[ch] || (gain_codes[ch] < ACR_GAIN_MIN);
            assign target    = want_mute ? ACR_GAIN_MIN : gain_codes[ch];

            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    app_q <= ACR_GAIN_MIN;
                else if (frame_sync && app_q < target)
                    app_q <= app_q + 7'h01;
                else if (frame_sync && app_q > target)
                    app_q <= app_q - 7'h01;
            end

            // mute engages only at the floor; releases on the clock after want_mute clears, even before any ramp-up step
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    mute_q <= 1'b1;
                else
                    mute_q <= want_mute && app_q == ACR_GAIN_MIN;
            end

            assign applied[ch]   = app_q;
            assign hard_mute[ch] = mute_q;
        end
    endgenerate

    assign rec_left_applied             = applied[0];
    assign rec_right_applied            = applied[1];
    assign rec_left_to_common_mode_ref  = hard_mute[0];
    assign rec_right_to_common_mode_ref = hard_mute[1];

endmodule

// File: dv/acr_regs_chk.sv
`timescale 1ns/100ps
module acr_regs_chk
    import acr_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        wr_en,
    input wire logic [3:0]  wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [3:0]  rd_addr,
    input wire logic [15:0] rd_data,
    input wire logic        frame_sync,
    input wire acr_cfg_t    cfg,
    input wire logic [6:0]  rec_left_applied,
    input wire logic [6:0]  rec_right_applied,
    input wire logic        rec_left_to_common_mode_ref,
    input wire logic        rec_right_to_common_mode_ref
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    sequence l_up_s;
        rec_left_applied > ACR_GAIN_MIN;
    endsequence
    sequence r_up_s;
        rec_right_applied > ACR_GAIN_MIN;
    endsequence
    cfg_hold_a: assert property (!frame_sync |=> $stable(cfg))
        else $error("cfg moved off frame");
    gain_idle_a: assert property (!frame_sync |=> $stable({rec_left_applied, rec_right_applied}))
        else $error("gain moved off frame");
    left_step_a: assert property (frame_sync |=> rec_left_applied - $past(rec_left_applied) + 7'h01 <= 7'h02)
        else $error("left gain jumped");
    right_step_a: assert property (frame_sync |=> rec_right_applied - $past(rec_right_applied) + 7'h01 <= 7'h02)
        else $error("right gain jumped");
    left_mute_a: assert property (l_up_s |-> !rec_left_to_common_mode_ref)
        else $error("left muted above floor");
    right_mute_a: assert property (r_up_s |-> !rec_right_to_common_mode_ref)
        else $error("right muted above floor");
    gain_read_a: assert property (wr_en && wr_addr == ACR_ADDR_GAIN ##1 rd_addr == ACR_ADDR_GAIN
        |-> rd_data == $past(wr_data)) else $error("gain word not read back");
    unmapped_a: assert property (rd_addr > ACR_ADDR_GAIN |-> rd_data == 16'h0000)
        else $error("unmapped read not zero");
    ctrl_top_a: assert property (rd_addr == ACR_ADDR_CTRL |-> rd_data[15:10] == 6'h00)
        else $error("control top bits set");
endmodule
bind acr_regs acr_regs_chk u_chk (.clk, .arst_n, .wr_en, .wr_addr, .wr_data, .rd_addr, .rd_data, .frame_sync,
    .cfg, .rec_left_applied, .rec_right_applied, .rec_left_to_common_mode_ref, .rec_right_to_common_mode_ref);

// File: dv/acr_host.sv
`timescale 1ns/100ps
module acr_host
(
    input  wire logic        clk,
    output logic             wr_en,
    output logic      [3:0]  wr_addr,
    output logic      [15:0] wr_data
);
    initial
    begin
        wr_en = 1'b0;
        wr_addr = 4'h0;
        wr_data = 16'h0000;
    end
    // released bus shows the inverse so a stale word never looks fresh
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        if (a == 4'h0 && d[5:2] > 4'h8)
            d[5:2] = 4'h8;
        @(posedge clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
    endtask
endmodule

// File: dv/test_acr_regs.sv
`timescale 1ns/100ps
module test_acr_regs;
    import acr_pkg::*;
    logic        clk = 1'b0, arst_n = 1'b0, fs = 1'b0, chk = 1'b0, wr_en, ml, mr;
    logic [3:0]  wr_addr, ra = 4'h0;
    logic [6:0]  dl, dr, al = 7'h07, ar = 7'h07;
    logic [15:0] wr_data, rd_data, ctl = 16'h0003, live = 16'h0003, gn = 16'hD7D7;
    logic [15:0] gw[4] = '{16'h7F05, 16'hFF06, 16'h7F85, 16'h2A57};
    logic [79:0] q[$];
    acr_cfg_t    cfg;
    int          fails = 0, compares = 0, cyc = 0;
    int          rt[9] = '{4800, 4410, 3200, 2400, 2205, 1600, 1200, 1105, 800};
    wire  [79:0] obs = {rd_data, cfg.mic_gain_db, cfg.mclk_ratio, cfg.rate_hz_x10, cfg.rate_code, cfg.frame,
        dl, dr, ml, mr};
    acr_host u_host (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
    acr_regs DUT (.clk(clk), .arst_n(arst_n), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(ra),
        .rd_data(rd_data), .frame_sync(fs), .cfg(cfg), .rec_left_applied(dl), .rec_right_applied(dr),
        .rec_left_to_common_mode_ref(ml), .rec_right_to_common_mode_ref(mr));
    always #10 clk = ~clk;
    function automatic logic [6:0] step(logic [6:0] a, logic m, logic [6:0] c);
        logic [6:0] t;
        t = (m || c < 7'h07) ? 7'h07 : c;
        return (a < t) ? a + 7'h01 : (a > t) ? a - 7'h01 : a;
    endfunction
    function automatic logic [79:0] ev();
        logic [1:0] m;
        m = live[9:8];
        return {ra == 4'h0 ? ctl : ra == 4'h1 ? gn : 16'h0000, 4'(m < 2 ? 0 : m == 2 ? 6 : 12),
            10'(live[7:6] == 1 ? 384 : live[7:6] == 2 ? 512 : 256), 17'(rt[live[5:2]]), live[5:2],
            5'(live[1:0] == 0 ? 16 : 20), live[1:0] < 2'h2, live[1:0] == 2'h3,
            5'(live[1:0] == 0 ? 16 : 20), live[1:0] == 2'h3, al, ar,
            (gn[15] || gn[14:8] < 7'h07) && al == 7'h07, (gn[7] || gn[6:0] < 7'h07) && ar == 7'h07};
    endfunction
    task automatic put(logic [3:0] a, logic [15:0] d);
        u_host.wr(a, d);
        if (a == 4'h0)
            ctl = {6'h00, d[9:0]};
        else if (a == 4'h1)
            gn = d;
    endtask
    task automatic frame();
        @(posedge clk);
        fs <= 1'b1;
        @(posedge clk);
        fs <= 1'b0;
        live = ctl;
        al = step(al, gn[15], gn[14:8]);
        ar = step(ar, gn[7], gn[6:0]);
    endtask
    task automatic check();
        @(posedge clk);
        ra <= 4'($urandom_range(3));
        @(posedge clk);
        chk <= 1'b1;
        q.push_back(ev());
        @(posedge clk);
        chk <= 1'b0;
    endtask
    task automatic tally_and_finish();
        if (fails == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(negedge clk)
    begin
        cyc++;
        if (chk)
        begin
            compares++;
            if (obs !== q[0])
            begin
                fails++;
                $display("mismatch t=%0t got %h exp %h", $time, obs, q[0]);
            end
            void'(q.pop_front());
        end
        if (cyc > 20000)
        begin
            fails++;
            tally_and_finish();
        end
    end
    initial
    begin
        void'($urandom(41348));
        gw[3][14:8] = 7'($urandom_range(127));
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        check();
        for (int i = 0; i < 12; i++)
        begin
            put(4'h0, {6'($urandom), 4'($urandom), 4'(i % 9), 2'(i)});
            check();
            frame();
            check();
        end
        put(4'h9, 16'hFFFF);
        foreach (gw[k])
        begin
            put(4'h1, gw[k]);
            repeat (90)
            begin
                frame();
                check();
            end
        end
        tally_and_finish();
    end
endmodule
